// *** cco_pkg.sv ***
package cco_pkg;
   localparam int ADDR_W = 32;
   localparam int WC_W = 16;
   localparam int LINE_WORDS_W = 4;
   localparam logic [WC_W-1:0] LINE_WORDS = 16'h0010;
   localparam logic [WC_W-1:0] WC_ZERO = 16'h0000;
   localparam logic [3:0] NOP_COUNT = 4'hf;
   localparam int GLOBAL_SETS_W = 8;
   localparam logic [GLOBAL_SETS_W-1:0] GLOBAL_SETS = 8'hff;

   typedef enum logic [2:0] {
      CCO_L1D_BLK_INV,
      CCO_L1D_BLK_WB,
      CCO_L1D_BLK_WRITEBACK_INVALIDATE_OP,
      CCO_L2_BLK_INV,
      CCO_L2_BLK_WB,
      CCO_L2_BLK_WRITEBACK_INVALIDATE_OP
   } cco_blk_kind_t;

   typedef enum logic [2:0] {
      CCO_G_L1D_INV,
      CCO_G_L1D_WRITEBACK_INVALIDATE_OP,
      CCO_G_L2_INV,
      CCO_G_L2_WRITEBACK_INVALIDATE_OP,
      CCO_G_L1D_WB,
      CCO_G_L2_WB
   } cco_glb_kind_t;
endpackage : cco_pkg

// *** cco_if.sv ***
interface cco_if;
   logic bar_wr;
   logic [cco_pkg::ADDR_W-1:0] bar_data;
   logic wc_wr;
   cco_pkg::cco_blk_kind_t blk_kind;
   logic [cco_pkg::WC_W-1:0] wc_data;
   logic glb_wr;
   cco_pkg::cco_glb_kind_t glb_kind;
   logic [cco_pkg::WC_W-1:0] block_word_count_reg;
   logic [5:0] glb_status;
   logic barrier_req;
   logic barrier_stall;
   logic freeze;
   logic cpu_access;
   logic cpu_write;
   logic cpu_miss;
   logic [7:0] cpu_set;

   modport device (
      input bar_wr, bar_data, wc_wr, blk_kind, wc_data, glb_wr, glb_kind,
      input barrier_req, freeze, cpu_access, cpu_write, cpu_miss, cpu_set,
      output block_word_count_reg, glb_status, barrier_stall
   );
   modport host (
      output bar_wr, bar_data, wc_wr, blk_kind, wc_data, glb_wr, glb_kind,
      output barrier_req, freeze, cpu_access, cpu_write, cpu_miss, cpu_set,
      input block_word_count_reg, glb_status, barrier_stall
   );
endinterface : cco_if

// *** cco_device.sv ***
module cco_device (
   input wire logic clock,
   input wire logic rst,
   cco_if.device bus,
   output logic busy,
   output logic op_invalidating,
   output logic [7:0] op_set,
   output logic cpu_hold
);
   typedef enum {CCO_IDLE, CCO_BLOCK, CCO_GLOBAL} cco_state_t;

   cco_state_t state_r, state_nxt;
   logic [cco_pkg::ADDR_W-1:0] base_r, base_nxt;
   logic [cco_pkg::WC_W-1:0] wc_r, wc_nxt;
   logic [cco_pkg::GLOBAL_SETS_W-1:0] gset_r, gset_nxt;
   logic [5:0] glb_r, glb_nxt;
   logic inval_r, inval_nxt;
   logic stall_r, stall_nxt;
   logic hold_r, hold_nxt;
   logic busy_r, busy_nxt;
   logic [7:0] set_r, set_nxt;
   logic miss_pend_r, miss_pend_nxt;
   logic [7:0] miss_set_r, miss_set_nxt;
   logic hazard;

   // hazard: pending write miss collides with an invalidate in the same set
   assign hazard = miss_pend_r && inval_r && (miss_set_r == set_r);

   always_comb begin
      state_nxt = state_r;
      base_nxt = base_r;
      wc_nxt = wc_r;
      gset_nxt = gset_r;
      glb_nxt = glb_r;
      inval_nxt = inval_r;
      set_nxt = set_r;
      miss_pend_nxt = miss_pend_r;
      miss_set_nxt = miss_set_r;
      if (bus.bar_wr && state_r == CCO_IDLE) begin
         base_nxt = bus.bar_data;
      end
      if (bus.cpu_access && bus.cpu_write && bus.cpu_miss) begin
         miss_pend_nxt = 1'b1;
         miss_set_nxt = bus.cpu_set;
      end else if (!bus.cpu_access) begin
         miss_pend_nxt = 1'b0;
      end
      case (state_r)
         CCO_IDLE: begin
            if (bus.wc_wr && bus.wc_data != cco_pkg::WC_ZERO) begin
               state_nxt = CCO_BLOCK;
               wc_nxt = bus.wc_data;
               inval_nxt = (bus.blk_kind != cco_pkg::CCO_L1D_BLK_WB) &&
                           (bus.blk_kind != cco_pkg::CCO_L2_BLK_WB);
               set_nxt = base_r[11:4];
            end else if (bus.glb_wr) begin
               state_nxt = CCO_GLOBAL;
               glb_nxt = 6'h00;
               glb_nxt[bus.glb_kind] = 1'b1;
               gset_nxt = cco_pkg::GLOBAL_SETS;
               inval_nxt = (bus.glb_kind != cco_pkg::CCO_G_L1D_WB) &&
                           (bus.glb_kind != cco_pkg::CCO_G_L2_WB);
               set_nxt = 8'h00;
            end
         end
         CCO_BLOCK: begin
            // a line stalls every cycle that the hazard stands, never skipped
            if (!hazard) begin
               if (wc_r > cco_pkg::LINE_WORDS) begin
                  wc_nxt = wc_r - cco_pkg::LINE_WORDS;
                  set_nxt = set_r + 8'h01;
               end else begin
                  wc_nxt = cco_pkg::WC_ZERO;
                  inval_nxt = 1'b0;
                  state_nxt = CCO_IDLE;
               end
            end
         end
         CCO_GLOBAL: begin
            if (!hazard) begin
               if (gset_r != 8'h00) begin
                  gset_nxt = gset_r - 8'h01;
                  set_nxt = set_r + 8'h01;
               end else begin
                  glb_nxt = 6'h00;
                  inval_nxt = 1'b0;
                  state_nxt = CCO_IDLE;
               end
            end
         end
         default: state_nxt = CCO_IDLE;
      endcase
   end

   always_comb begin
      // stall the barrier while anything is running or about to start
      stall_nxt = bus.barrier_req && (state_nxt != CCO_IDLE);
      // frozen cache: writeback-invalidate runs beside cpu traffic
      hold_nxt = (state_nxt != CCO_IDLE) && inval_nxt && !bus.freeze;
      busy_nxt = (state_nxt != CCO_IDLE);
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         state_r <= CCO_IDLE;
         base_r <= '0;
         wc_r <= cco_pkg::WC_ZERO;
         gset_r <= '0;
         glb_r <= 6'h00;
         inval_r <= 1'b0;
         set_r <= 8'h00;
         miss_pend_r <= 1'b0;
         miss_set_r <= 8'h00;
         stall_r <= 1'b0;
         hold_r <= 1'b0;
         busy_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         base_r <= base_nxt;
         wc_r <= wc_nxt;
         gset_r <= gset_nxt;
         glb_r <= glb_nxt;
         inval_r <= inval_nxt;
         set_r <= set_nxt;
         miss_pend_r <= miss_pend_nxt;
         miss_set_r <= miss_set_nxt;
         stall_r <= stall_nxt;
         hold_r <= hold_nxt;
         busy_r <= busy_nxt;
      end
   end

   assign bus.block_word_count_reg = wc_r;
   assign bus.glb_status = glb_r;
   assign bus.barrier_stall = stall_r;
   assign busy = busy_r;
   assign op_invalidating = inval_r;
   assign op_set = set_r;
   assign cpu_hold = hold_r;
endmodule : cco_device

// *** cco_host.sv ***
module cco_host (
   input wire logic clock,
   input wire logic rst,
   cco_if.host bus,
   input wire logic start_block,
   input wire logic start_global,
   input wire logic [cco_pkg::ADDR_W-1:0] req_addr,
   input wire logic [cco_pkg::WC_W-1:0] req_count,
   input wire cco_pkg::cco_blk_kind_t req_blk_kind,
   input wire cco_pkg::cco_glb_kind_t req_glb_kind,
   input wire logic use_freeze,
   output logic done,
   output logic irq_masked
);
   typedef enum {H_IDLE, H_BAR, H_WC, H_GLB, H_WAIT, H_NOPS, H_UNFREEZE} cco_hstate_t;

   cco_hstate_t st_r, st_nxt;
   logic [3:0] nop_r, nop_nxt;
   logic done_r, done_nxt;
   logic mask_r, mask_nxt;
   logic frz_r, frz_nxt;
   logic blk_r, blk_nxt;
   logic finished;

   // completion seen by polling, allowed one cycle after issue
   assign finished = blk_r ? (bus.block_word_count_reg == cco_pkg::WC_ZERO)
                           : (bus.glb_status == 6'h00);

   always_comb begin
      st_nxt = st_r;
      nop_nxt = nop_r;
      done_nxt = 1'b0;
      mask_nxt = mask_r;
      frz_nxt = frz_r;
      blk_nxt = blk_r;
      case (st_r)
         H_IDLE: begin
            if (start_block) begin
               st_nxt = H_BAR;
               blk_nxt = 1'b1;
               mask_nxt = !use_freeze;
               frz_nxt = use_freeze;
            end else if (start_global) begin
               st_nxt = H_GLB;
               blk_nxt = 1'b0;
               mask_nxt = 1'b1;
            end
         end
         H_BAR: st_nxt = H_WC;
         H_WC: st_nxt = H_WAIT;
         H_GLB: st_nxt = H_WAIT;
         H_WAIT: begin
            if (finished && !bus.barrier_stall) begin
               st_nxt = frz_r ? H_UNFREEZE : H_NOPS;
               nop_nxt = cco_pkg::NOP_COUNT;
            end
         end
         H_NOPS: begin
            if (nop_r == 4'h0) begin
               st_nxt = H_IDLE;
               mask_nxt = 1'b0;
               done_nxt = 1'b1;
            end else begin
               nop_nxt = nop_r - 4'h1;
            end
         end
         H_UNFREEZE: begin
            frz_nxt = 1'b0;
            st_nxt = H_IDLE;
            done_nxt = 1'b1;
         end
         default: st_nxt = H_IDLE;
      endcase
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         st_r <= H_IDLE;
         nop_r <= 4'h0;
         done_r <= 1'b0;
         mask_r <= 1'b0;
         frz_r <= 1'b0;
         blk_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         nop_r <= nop_nxt;
         done_r <= done_nxt;
         mask_r <= mask_nxt;
         frz_r <= frz_nxt;
         blk_r <= blk_nxt;
      end
   end

   assign bus.bar_wr = (st_r == H_BAR);
   assign bus.bar_data = req_addr;
   assign bus.wc_wr = (st_r == H_WC);
   assign bus.wc_data = req_count;
   assign bus.blk_kind = req_blk_kind;
   assign bus.glb_wr = (st_r == H_GLB);
   assign bus.glb_kind = req_glb_kind;
   // barrier raised while waiting, and before unfreezing
   assign bus.barrier_req = (st_r == H_WAIT);
   assign bus.freeze = frz_r;
   assign bus.cpu_access = 1'b0;
   assign bus.cpu_write = 1'b0;
   assign bus.cpu_miss = 1'b0;
   assign bus.cpu_set = 8'h00;
   assign done = done_r;
   assign irq_masked = mask_r;
endmodule : cco_host

// *** cco_sva.sv ***
module cco_sva (
   input wire logic clock,
   input wire logic rst,
   input wire logic wc_wr,
   input wire logic [cco_pkg::WC_W-1:0] wc_data,
   input wire logic glb_wr,
   input wire cco_pkg::cco_glb_kind_t glb_kind,
   input wire logic [cco_pkg::WC_W-1:0] block_word_count_reg,
   input wire logic [5:0] glb_status,
   input wire logic barrier_stall,
   input wire logic cpu_miss
);
   default clocking @(posedge clock);
   endclocking
   default disable iff (rst);
   sequence blk_start_s;
      wc_wr && wc_data != 16'h0000 && block_word_count_reg == 16'h0000 && glb_status == 6'h00;
   endsequence
   sequence glb_run_s;
      $rose(glb_status != 6'h00);
   endsequence
   blk_load_a: assert property (blk_start_s |=> block_word_count_reg == $past(wc_data))
      else $error("count not loaded from write");
   cnt_step_a: assert property ((block_word_count_reg != 16'h0000 && !cpu_miss) |=>
      (block_word_count_reg == 16'h0000 ||
       block_word_count_reg == $past(block_word_count_reg) - cco_pkg::LINE_WORDS))
      else $error("count did not step by one line");
   cnt_hold_a: assert property ((block_word_count_reg == 16'h0000 &&
      !(wc_wr && wc_data != 16'h0000)) |=> block_word_count_reg == 16'h0000)
      else $error("idle count left zero");
   glb_load_a: assert property ((glb_wr && glb_status == 6'h00 &&
      block_word_count_reg == 16'h0000) |=> glb_status == (6'h01 << $past(glb_kind)))
      else $error("global status bit wrong");
   glb_onehot_a: assert property (glb_status == 6'h00 || $onehot(glb_status))
      else $error("global status not one-hot");
   glb_hold_a: assert property (glb_run_s |-> (glb_status != 6'h00)[*8])
      else $error("global bit dropped early");
   glb_end_a: assert property (glb_run_s |-> ##[250:270] glb_status == 6'h00)
      else $error("global bit not cleared in time");
   stall_busy_a: assert property (((block_word_count_reg != 16'h0000 || glb_status != 6'h00)
      ##1 (block_word_count_reg != 16'h0000 || glb_status != 6'h00)) |-> barrier_stall)
      else $error("barrier not stalled while busy");
endmodule : cco_sva

// *** tb_l2_cache_coherence_ops.sv ***
module tb_l2_cache_coherence_ops;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock, rst, start_block, start_global, use_freeze, done, irq_masked, busy, op_inv;
   logic [31:0] req_addr;
   logic cpu_hold;
   logic [7:0] op_set;
   logic [15:0] req_count;
   cco_pkg::cco_blk_kind_t req_blk_kind;
   cco_pkg::cco_glb_kind_t req_glb_kind;
   logic [15:0] cnts [6] = '{16'h0001, 16'h0010, 16'h0011, 16'h0040, 16'h00ff, 16'h0020};
   int failures, checks_done, i;
   cco_if i_cco_if();
   cco_device i_cco_device(.clock(clock), .rst(rst), .bus(i_cco_if), .busy(busy),
      .op_invalidating(op_inv), .op_set(op_set), .cpu_hold(cpu_hold));
   cco_host i_cco_host(.clock(clock), .rst(rst), .bus(i_cco_if), .start_block(start_block),
      .start_global(start_global), .req_addr(req_addr), .req_count(req_count),
      .req_blk_kind(req_blk_kind), .req_glb_kind(req_glb_kind), .use_freeze(use_freeze),
      .done(done), .irq_masked(irq_masked));
   cco_sva i_cco_sva(.clock(clock), .rst(rst), .wc_wr(i_cco_if.wc_wr),
      .wc_data(i_cco_if.wc_data), .glb_wr(i_cco_if.glb_wr), .glb_kind(i_cco_if.glb_kind),
      .block_word_count_reg(i_cco_if.block_word_count_reg), .glb_status(i_cco_if.glb_status),
      .barrier_stall(i_cco_if.barrier_stall), .cpu_miss(i_cco_if.cpu_miss));
   task close_out;
      if (failures == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : close_out
   task chk(input logic ok, input string m);
      checks_done++;
      if (ok !== 1'b1) begin
         failures++;
         $display("Error %0t: %s", $time, m);
      end
   endtask : chk
   // a stuck handshake ends the run rather than hanging it
   task guard(input int n);
      if (n >= 4000) begin
         failures++;
         close_out();
      end
   endtask : guard
   task wait_done(output int z);
      for (z = 0; z < 4000 && done !== 1'b1; z++) @(negedge clock);
      guard(z);
   endtask : wait_done
   task finish_op;
      int n;
      wait_done(n);
      chk(i_cco_if.barrier_stall === 1'b0 && busy === 1'b0, "still busy");
      @(negedge clock);
      chk(irq_masked === 1'b0, "irq kept masked");
   endtask : finish_op
   task run_block(input logic [15:0] cnt, input cco_pkg::cco_blk_kind_t k, input logic frz);
      int n;
      req_count = cnt;
      req_blk_kind = k;
      use_freeze = frz;
      start_block = 1'b1;
      @(negedge clock);
      start_block = 1'b0;
      for (n = 0; n < 4000 && i_cco_if.block_word_count_reg === 16'h0000; n++) @(negedge clock);
      guard(n);
      chk(i_cco_if.block_word_count_reg === cnt, "count load");
      chk(op_inv === (k != cco_pkg::CCO_L1D_BLK_WB && k != cco_pkg::CCO_L2_BLK_WB), "inv");
      chk(irq_masked === !frz, "irq open");
      chk(cpu_hold === ((k != cco_pkg::CCO_L1D_BLK_WB && k != cco_pkg::CCO_L2_BLK_WB) && !frz),
         "cpu hold");
      chk(op_set === req_addr[11:4], "set index");
      @(negedge clock);
      chk(i_cco_if.block_word_count_reg === ((cnt > 16'h0010) ? cnt - 16'h0010 : 16'h0000),
         "count step");
      chk(i_cco_if.barrier_stall === (cnt > 16'h0010), "no stall");
      for (n = 0; n < 4000 && i_cco_if.block_word_count_reg !== 16'h0000; n++) @(negedge clock);
      guard(n);
      wait_done(n);
      chk(n >= (frz ? 1 : 16), "idle gap short");
      chk(i_cco_if.barrier_stall === 1'b0 && busy === 1'b0, "still busy");
      @(negedge clock);
      chk(irq_masked === 1'b0, "irq kept masked");
   endtask : run_block
   task run_global(input cco_pkg::cco_glb_kind_t k);
      int n;
      req_glb_kind = k;
      start_global = 1'b1;
      @(negedge clock);
      start_global = 1'b0;
      for (n = 0; n < 4000 && i_cco_if.glb_status === 6'h00; n++) @(negedge clock);
      guard(n);
      chk(i_cco_if.glb_status === (6'h01 << k), "global bit");
      chk(op_inv === (k < cco_pkg::CCO_G_L1D_WB), "inv");
      for (n = 0; n < 4000 && i_cco_if.glb_status !== 6'h00; n++) @(negedge clock);
      guard(n);
      chk(n >= 250, "global short");
      finish_op();
   endtask : run_global
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   initial begin
      rst = 1'b1;
      start_block = 1'b0;
      start_global = 1'b0;
      use_freeze = 1'b0;
      req_addr = 32'h0000_1230;
      req_count = 16'h0000;
      req_blk_kind = cco_pkg::CCO_L1D_BLK_INV;
      req_glb_kind = cco_pkg::CCO_G_L1D_INV;
      failures = 0;
      checks_done = 0;
      repeat (20) @(negedge clock);
      rst = 1'b0;
      @(negedge clock);
      for (i = 0; i < 6; i++) run_block(cnts[i], cco_pkg::cco_blk_kind_t'(i), i[0]);
      for (i = 0; i < 6; i++) run_global(cco_pkg::cco_glb_kind_t'(i));
      close_out();
   end
endmodule : tb_l2_cache_coherence_ops
